// File: core/timer_capture_compare_ch0.sv
// Capture/compare timer channel 0 with an AXI4-Lite register file.
// Assumes a single clock CORE_CLK; the capture pin is asynchronous
// and is synchronised here before any use.
`timescale 1ns/1ns

module timer_capture_compare_ch0
#(
  parameter int CNT_WIDTH = 16
)
(
  input  wire logic                 CORE_CLK,
  input  wire logic                 RST,
  input  wire logic [7:0]           S_AXI_AWADDR,
  input  wire logic                 S_AXI_AWVALID,
  output logic                      S_AXI_AWREADY,
  input  wire logic [31:0]          S_AXI_WDATA,
  input  wire logic [3:0]           S_AXI_WSTRB,
  input  wire logic                 S_AXI_WVALID,
  output logic                      S_AXI_WREADY,
  output logic [1:0]                S_AXI_BRESP,
  output logic                      S_AXI_BVALID,
  input  wire logic                 S_AXI_BREADY,
  input  wire logic [7:0]           S_AXI_ARADDR,
  input  wire logic                 S_AXI_ARVALID,
  output logic                      S_AXI_ARREADY,
  output logic [31:0]               S_AXI_RDATA,
  output logic [1:0]                S_AXI_RRESP,
  output logic                      S_AXI_RVALID,
  input  wire logic                 S_AXI_RREADY,
  input  wire logic                 CAPTURE_INPUT_PIN,
  output logic                      CAPTURE_INPUT_PIN_OE,
  output logic                      CHANNEL_PIN_C_OE,
  output logic                      COMPARE_OUT_PIN_B,
  output logic                      COMPARE_OUT_PIN_B_OE,
  output logic                      COMPARE_OUT_PIN_D,
  output logic                      COMPARE_OUT_PIN_D_OE,
  output logic                      TIMER_IRQ
);
  import tcc_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic                 clk_supply;
  logic [3:0]           start_ctrl;
  logic [31:0]          mode;
  logic [31:0]          io_ctrl;
  logic [4:0]           irq_enable;
  logic [4:0]           status;
  logic [CNT_WIDTH-1:0] channel_counter;
  logic [CNT_WIDTH-1:0] capture_reg_a;
  logic [CNT_WIDTH-1:0] compare_reg_b;
  logic [CNT_WIDTH-1:0] buffer_reg_c;
  logic [CNT_WIDTH-1:0] compare_reg_d;
  logic [CNT_WIDTH-1:0] second_channel_counter;

  // Bus state
  logic                 aw_held;
  logic                 w_held;
  logic [7:0]           aw_addr;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 wr_fire;
  logic                 rd_fire;
  logic [31:0]          next_rdata;
  logic                 rd_known;
  logic                 wr_known;

  // Timer-side signals
  logic                 timer_rst;
  logic                 counting0;
  logic                 pin_meta;
  logic                 pin_sync;
  logic [2:0]           stable_cnt;
  logic                 filt_level;
  logic                 prev_level;
  logic                 use_level;
  logic                 rise_edge;
  logic                 fall_edge;
  logic                 capture_evt;
  logic                 match_a;
  logic                 match_b;
  logic                 match_d;
  logic                 overflow;
  logic [1:0]           edge_sel;
  logic                 clear_start0;

  // Write strobe helper: merge a byte-enabled write into a word
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction

  // Pin output rule from a 2-bit control and the current level
  function automatic logic pin_next(input logic [1:0] ctl,
                                    input logic       cur,
                                    input logic       hit);
    logic res;
    res = cur;
    if (hit)
    begin
      unique case (ctl)
        OUT_DISABLED: res = cur;
        OUT_LOW:      res = 1'b0;
        OUT_HIGH:     res = 1'b1;
        OUT_TOGGLE:   res = ~cur;
      endcase
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are taken in either order; response after both
  assign S_AXI_AWREADY = ~aw_held & ~S_AXI_BVALID;
  assign S_AXI_WREADY  = ~w_held & ~S_AXI_BVALID;
  assign wr_fire       = aw_held & w_held & ~S_AXI_BVALID;

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (wr_fire)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end

  // Writes to the timer registers are dropped while the supply is off
  always_comb
  begin
    unique case (aw_addr)
      OFF_CLK_ENABLE:  wr_known = 1'b1;
      OFF_START_CTRL, OFF_MODE, OFF_IO_CTRL, OFF_IRQ_ENABLE, OFF_STATUS,
      OFF_COUNTER, OFF_CAPTURE_A, OFF_COMPARE_B, OFF_BUFFER_C,
      OFF_COMPARE_D:   wr_known = 1'b1;
      default:         wr_known = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign S_AXI_ARREADY = ~S_AXI_RVALID;
  assign rd_fire       = S_AXI_ARVALID & S_AXI_ARREADY;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    rd_known   = 1'b1;
    unique case (S_AXI_ARADDR)
      OFF_CLK_ENABLE: next_rdata[CLK_SUPPLY_BIT] = clk_supply;
      OFF_START_CTRL: next_rdata[3:0] = start_ctrl;
      OFF_MODE:       next_rdata = mode;
      OFF_IO_CTRL:    next_rdata = io_ctrl;
      OFF_IRQ_ENABLE: next_rdata[4:0] = irq_enable;
      OFF_STATUS:     next_rdata[4:0] = status;
      OFF_COUNTER:    next_rdata[CNT_WIDTH-1:0] = channel_counter;
      OFF_CAPTURE_A:  next_rdata[CNT_WIDTH-1:0] = capture_reg_a;
      OFF_COMPARE_B:  next_rdata[CNT_WIDTH-1:0] = compare_reg_b;
      OFF_BUFFER_C:   next_rdata[CNT_WIDTH-1:0] = buffer_reg_c;
      OFF_COMPARE_D:  next_rdata[CNT_WIDTH-1:0] = compare_reg_d;
      default:        rd_known = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= next_rdata;
      S_AXI_RRESP  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_RREADY)
      S_AXI_RVALID <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Clock supply and start control
  // ----------------------------------------------------------------
  // Supply bit is always writable; everything else waits for it
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      clk_supply <= 1'b0;
    else if (wr_fire && aw_addr == OFF_CLK_ENABLE && w_strb[0])
      clk_supply <= w_data[CLK_SUPPLY_BIT];
  end

  assign timer_rst    = ~clk_supply;
  assign clear_start0 = counting0 & match_a & ~start_ctrl[CNT_OP_SEL_BIT];

  // Hardware stop at match A beats a simultaneous software start
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      start_ctrl <= 4'h0;
    else if (timer_rst)
      start_ctrl <= 4'h0;
    else
    begin
      if (wr_fire && aw_addr == OFF_START_CTRL && w_strb[0])
        start_ctrl <= w_data[3:0];
      if (clear_start0)
        start_ctrl[START0_BIT] <= 1'b0;
    end
  end

  // Configuration registers, writable only with supply on
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      mode          <= 32'h0000_0000;
      io_ctrl       <= 32'h0000_0000;
      irq_enable    <= 5'h00;
      compare_reg_b <= COMPARE_RESET;
      compare_reg_d <= COMPARE_RESET;
    end
    else if (timer_rst)
    begin
      mode          <= 32'h0000_0000;
      io_ctrl       <= 32'h0000_0000;
      irq_enable    <= 5'h00;
      compare_reg_b <= COMPARE_RESET;
      compare_reg_d <= COMPARE_RESET;
    end
    else if (wr_fire)
    begin
      unique case (aw_addr)
        OFF_MODE:       mode <= merge(mode, w_data, w_strb);
        OFF_IO_CTRL:    io_ctrl <= merge(io_ctrl, w_data, w_strb);
        OFF_IRQ_ENABLE: irq_enable <= 5'(merge(32'(irq_enable), w_data, w_strb));
        OFF_COMPARE_B:  compare_reg_b <= CNT_WIDTH'(merge(32'(compare_reg_b), w_data,
                                                          w_strb));
        OFF_COMPARE_D:  compare_reg_d <= CNT_WIDTH'(merge(32'(compare_reg_d), w_data,
                                                          w_strb));
        default:        ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  assign counting0 = start_ctrl[START0_BIT];
  assign overflow  = counting0 & (&channel_counter);
  assign match_a   = capture_reg_a == channel_counter;
  assign match_b   = counting0 & (compare_reg_b == channel_counter);
  assign match_d   = counting0 & (compare_reg_d == channel_counter);

  // Runs until match A stops it (count_operation_select 0); no capture or compare ever clears the count
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      channel_counter <= COUNTER_RESET;
    else if (timer_rst)
      channel_counter <= COUNTER_RESET;
    else if (wr_fire && aw_addr == OFF_COUNTER)
      channel_counter <= w_data[CNT_WIDTH-1:0];
    else if (counting0)
      channel_counter <= channel_counter + 1'b1;
  end

  // Second counter has its own start bit; it shares only the supply-off clear
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      second_channel_counter <= COUNTER_RESET;
    else if (timer_rst)
      second_channel_counter <= COUNTER_RESET;
    else if (start_ctrl[START1_BIT])
      second_channel_counter <= second_channel_counter + 1'b1;
  end

  // ----------------------------------------------------------------
  // Capture pin: synchroniser, filter, edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= CAPTURE_INPUT_PIN;
      pin_sync <= pin_meta;
    end
  end

  // Filter samples every core clock, the count source
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      stable_cnt <= 3'h0;
      filt_level <= 1'b0;
    end
    else if (pin_sync == filt_level)
      stable_cnt <= 3'h0;
    else if (stable_cnt == 3'(FILTER_HOLD_CYC - 1))
    begin
      filt_level <= pin_sync;
      stable_cnt <= 3'h0;
    end
    else
      stable_cnt <= stable_cnt + 3'h1;
  end

  assign use_level = mode[MODE_FILTER_BIT] ? filt_level : pin_sync;
  assign edge_sel  = io_ctrl[IO_EDGE_LSB +: 2];
  assign rise_edge = use_level & ~prev_level;
  assign fall_edge = ~use_level & prev_level;

  // Reserved code 11 captures nothing
  always_comb
  begin
    unique case (edge_sel)
      EDGE_RISE: capture_evt = rise_edge;
      EDGE_FALL: capture_evt = fall_edge;
      EDGE_BOTH: capture_evt = rise_edge | fall_edge;
      default:   capture_evt = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      prev_level    <= 1'b0;
      capture_reg_a <= COUNTER_RESET;
      buffer_reg_c  <= COUNTER_RESET;
    end
    else if (timer_rst)
    begin
      prev_level    <= use_level;
      capture_reg_a <= COUNTER_RESET;
      buffer_reg_c  <= COUNTER_RESET;
    end
    else
    begin
      prev_level <= use_level;
      if (capture_evt)
      begin
        capture_reg_a <= channel_counter;
        if (mode[MODE_BUF_C_BIT])
          buffer_reg_c <= capture_reg_a;
      end
      else if (wr_fire && aw_addr == OFF_CAPTURE_A)
        capture_reg_a <= w_data[CNT_WIDTH-1:0];
      else if (wr_fire && aw_addr == OFF_BUFFER_C)
        buffer_reg_c <= w_data[CNT_WIDTH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Status flags; set wins over a software write-one clear
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      status <= 5'h00;
    else if (timer_rst)
      status <= 5'h00;
    else
    begin
      if (wr_fire && aw_addr == OFF_STATUS && w_strb[0])
        status <= status & ~w_data[4:0];
      if (capture_evt)
        status[ST_A_BIT] <= 1'b1;
      if (match_b)
        status[ST_B_BIT] <= 1'b1;
      if (match_d)
        status[ST_D_BIT] <= 1'b1;
      if (overflow)
        status[ST_OVF_BIT] <= 1'b1;
    end
  end

  // Each source reaches the line only through its own enable
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      TIMER_IRQ <= 1'b0;
    else
      TIMER_IRQ <= |(status & irq_enable);
  end

  // ----------------------------------------------------------------
  // Compare output pins
  // ----------------------------------------------------------------
  // Initial level is loaded whenever the channel is stopped
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      COMPARE_OUT_PIN_B <= 1'b0;
      COMPARE_OUT_PIN_D <= 1'b0;
    end
    else if (timer_rst || !counting0)
    begin
      COMPARE_OUT_PIN_B <= io_ctrl[IO_INIT_B_BIT];
      COMPARE_OUT_PIN_D <= io_ctrl[IO_INIT_D_BIT];
    end
    else
    begin
      COMPARE_OUT_PIN_B <= pin_next(io_ctrl[IO_OUT_B_LSB +: 2],
                                    COMPARE_OUT_PIN_B, match_b);
      COMPARE_OUT_PIN_D <= pin_next(io_ctrl[IO_OUT_D_LSB +: 2],
                                    COMPARE_OUT_PIN_D, match_d);
    end
  end

  // Per-pin output enables
  assign CAPTURE_INPUT_PIN_OE = io_ctrl[IO_OE_A_BIT] & clk_supply;
  assign CHANNEL_PIN_C_OE     = io_ctrl[IO_OE_C_BIT] & clk_supply;
  assign COMPARE_OUT_PIN_B_OE = (io_ctrl[IO_OUT_B_LSB +: 2] != OUT_DISABLED);
  assign COMPARE_OUT_PIN_D_OE = (io_ctrl[IO_OUT_D_LSB +: 2] != OUT_DISABLED);

endmodule

// File: core/tcc_pkg.sv
// Constants for the capture/compare timer channel: register offsets,
// field positions, reset values and timing figures.
// Assumes an AXI4-Lite slave with 32-bit data and byte addressing.
package tcc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CLK_ENABLE  = 8'h00; // peripheral_clock_enable_1
  localparam logic [7:0] OFF_START_CTRL  = 8'h04; // timer_start_control
  localparam logic [7:0] OFF_MODE        = 8'h08;
  localparam logic [7:0] OFF_IO_CTRL     = 8'h0c;
  localparam logic [7:0] OFF_IRQ_ENABLE  = 8'h10;
  localparam logic [7:0] OFF_STATUS      = 8'h14;
  localparam logic [7:0] OFF_COUNTER     = 8'h18;
  localparam logic [7:0] OFF_CAPTURE_A   = 8'h1c;
  localparam logic [7:0] OFF_COMPARE_B   = 8'h20;
  localparam logic [7:0] OFF_BUFFER_C    = 8'h24;
  localparam logic [7:0] OFF_COMPARE_D   = 8'h28;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CLK_SUPPLY_BIT   = 4;  // timer_clock_supply_bit
  localparam int START0_BIT       = 0;  // channel0_start_bit
  localparam int START1_BIT       = 1;
  localparam int CNT_OP_SEL_BIT   = 2;  // count_operation_select
  localparam int MODE_BUF_C_BIT   = 4;  // register C buffers register A
  localparam int MODE_BUF_D_BIT   = 5;  // D-buffers-B select; no logic reads it
  localparam int MODE_FILTER_BIT  = 8;  // input_filter_enable
  localparam int IO_EDGE_LSB      = 0;  // capture edge select, 2 bits
  localparam int IO_OUT_B_LSB     = 4;  // compare out control B, 2 bits
  localparam int IO_OUT_D_LSB     = 8;  // compare out control D, 2 bits
  localparam int IO_INIT_B_BIT    = 12; // initial level of pin B
  localparam int IO_INIT_D_BIT    = 13; // initial level of pin D
  localparam int IO_OE_A_BIT      = 16; // output enable, capture pin
  localparam int IO_OE_C_BIT      = 18; // output enable, pin C
  localparam int IE_A_BIT         = 0;
  localparam int IE_B_BIT         = 1;
  localparam int IE_D_BIT         = 3;
  localparam int IE_OVF_BIT       = 4;
  localparam int ST_A_BIT         = 0;
  localparam int ST_B_BIT         = 1;
  localparam int ST_D_BIT         = 3;
  localparam int ST_OVF_BIT       = 4;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNTER_RESET  = 16'h0000;
  localparam logic [15:0] COMPARE_RESET  = 16'hffff;
  localparam logic [1:0]  EDGE_RISE      = 2'h0;
  localparam logic [1:0]  EDGE_FALL      = 2'h1;
  localparam logic [1:0]  EDGE_BOTH      = 2'h2;
  localparam logic [1:0]  OUT_DISABLED   = 2'h0;
  localparam logic [1:0]  OUT_LOW        = 2'h1;
  localparam logic [1:0]  OUT_HIGH       = 2'h2;
  localparam logic [1:0]  OUT_TOGGLE     = 2'h3;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_MHZ      = 125;
  localparam int FILTER_HOLD_CYC   = 5;    // filter sampling clocks
  localparam int PIN_B_DELAY_US    = 1000;
  localparam int PIN_D_DELAY_US    = 2000;
  localparam int PIN_B_DELAY_CYC   = PIN_B_DELAY_US * CORE_CLK_MHZ;
  localparam int PIN_D_DELAY_CYC   = PIN_D_DELAY_US * CORE_CLK_MHZ;

endpackage

// File: dv/tcc_sva.sv
// Bus answer checks for the timer channel.
// Assumes it is bound to the channel top and sees its ports only.
`timescale 1ns/1ns
module tcc_sva
(
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // Answers waiting on the master, and a write taken in one edge
  sequence b_wait; S_AXI_BVALID && !S_AXI_BREADY; endsequence
  sequence r_wait; S_AXI_RVALID && !S_AXI_RREADY; endsequence
  sequence both_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  a_bresp_held: assert property (b_wait |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped early");
  a_rdata_held: assert property (r_wait |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped early");
  a_bvalid_ends: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write answer repeated");
  a_rvalid_ends: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read answer repeated");
  a_aw_blocked: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
    else $error("address taken during answer");
  a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken during answer");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  a_write_answer: assert property (both_taken |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
    else $error("write answer not on time");
endmodule

bind timer_capture_compare_ch0 tcc_sva u_sva (.*);

// File: dv/tcc_pulse_src.sv
// Pulse source standing on the capture pin.
// Assumes requests from the bench on the core clock.
`timescale 1ns/1ns
module tcc_pulse_src
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic [7:0] len,
  output logic            pin
);
  logic [7:0] left;
  // Flip on request; a nonzero length flips back, making a short glitch
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin <= 1'b0;
      left <= 8'h00;
    end
    else if (go)
    begin
      pin <= ~pin;
      left <= len;
    end
    else if (left != 8'h00)
    begin
      left <= left - 8'h01;
      pin <= (left == 8'h01) ? ~pin : pin;
    end
  end
endmodule

// File: dv/test_timer_capture_compare_ch0.sv
// Self-checking bench for the timer channel.
// Assumes the package constants and a 125 MHz core clock.
`timescale 1ns/1ns
module test_timer_capture_compare_ch0;
  import tcc_pkg::*;
  logic CORE_CLK, RST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic S_AXI_RREADY, CAPTURE_INPUT_PIN, CAPTURE_INPUT_PIN_OE, CHANNEL_PIN_C_OE;
  logic COMPARE_OUT_PIN_B, COMPARE_OUT_PIN_B_OE, COMPARE_OUT_PIN_D;
  logic COMPARE_OUT_PIN_D_OE, TIMER_IRQ, go;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, len;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rv, a1;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, md[5];
  logic [33:0] exp_q[$], msk_q[$], m;
  localparam logic [33:0] FULL = {34{1'b1}};
  int n_errors, checks, t1, t2;
  int cyc = 0;
  timer_capture_compare_ch0 dut (.*);
  tcc_pulse_src src (.clk(CORE_CLK), .rst(RST), .go(go), .len(len), .pin(CAPTURE_INPUT_PIN));
  task automatic check(string what, logic [33:0] seen, logic [33:0] want);
    checks++;
    if (seen !== want)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge CORE_CLK);
  endtask
  // Write: both channels offered together, each dropped once taken
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (pa | pw)
    begin
      @(negedge CORE_CLK);
      pa = pa && !S_AXI_AWREADY;
      pw = pw && !S_AXI_WREADY;
      @(posedge CORE_CLK);
      S_AXI_AWVALID <= pa;
      S_AXI_WVALID <= pw;
    end
    do @(negedge CORE_CLK); while (!S_AXI_BVALID);
    check("bresp", S_AXI_BRESP, RESP_OKAY);
    @(posedge CORE_CLK);
    S_AXI_BREADY <= 1'b0;
  endtask
  // Read: the expectation is queued, the monitor compares it
  task automatic rd(logic [7:0] a, logic [33:0] e, logic [33:0] mk);
    exp_q.push_back(e & mk);
    msk_q.push_back(mk);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do @(negedge CORE_CLK); while (!S_AXI_ARREADY);
    @(posedge CORE_CLK);
    S_AXI_ARVALID <= 1'b0;
    do @(negedge CORE_CLK); while (!S_AXI_RVALID);
    rv = S_AXI_RDATA;
    @(posedge CORE_CLK);
    S_AXI_RREADY <= 1'b0;
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Monitor: each read answer against the oldest note
  always @(negedge CORE_CLK)
  begin
    if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      m = msk_q.pop_front();
      check("read", {S_AXI_RRESP, S_AXI_RDATA} & m, exp_q.pop_front());
    end
  end
  // Counted on the falling edge so that stamps taken at the rising edge never race it
  always @(negedge CORE_CLK) cyc++;
  initial
  begin
    CORE_CLK = 1'b0;
    forever #4 CORE_CLK = ~CORE_CLK;
  end
  // Watchdog: the whole run needs about a thousand cycles
  initial
  begin
    wt(30000);
    n_errors++;
    finish_test();
  end
  initial
  begin
    {RST, S_AXI_WSTRB} = {1'b1, 4'hf};
    md = '{OUT_DISABLED, OUT_LOW, OUT_HIGH, OUT_HIGH, OUT_TOGGLE};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY, go} = 6'h00;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, len} = 56'h0;
    void'($urandom(53));
    wt(20);
    RST <= 1'b0;
    wt(1);
    rd(OFF_COMPARE_B, {RESP_OKAY, 16'h0, COMPARE_RESET}, FULL);
    rd(8'h2c, {RESP_SLVERR, 32'h0}, FULL);
    wr(OFF_COMPARE_B, 32'h1234);
    rd(OFF_COMPARE_B, {RESP_OKAY, 16'h0, COMPARE_RESET}, FULL);
    wr(OFF_CLK_ENABLE, 32'h10);
    wr(OFF_COUNTER, 32'hff00);
    wr(OFF_COMPARE_B, 32'hff40);
    wr(OFF_COMPARE_D, 32'hff80);
    wr(OFF_IO_CTRL, 32'h0222); // Both edges, B and D high on match
    wr(OFF_MODE, 32'h0110);
    wr(OFF_IRQ_ENABLE, 32'h0011);
    rd(OFF_COUNTER, {RESP_OKAY, 32'hff00}, FULL);
    check("pin_b", COMPARE_OUT_PIN_B, 1'b0);
    $display("test setup done");
    wr(OFF_START_CTRL, 32'h5);
    wt(80);
    @(negedge CORE_CLK);
    check("pin_b", COMPARE_OUT_PIN_B, 1'b1);
    check("pin_d", COMPARE_OUT_PIN_D, 1'b0);
    check("oe", {CAPTURE_INPUT_PIN_OE, CHANNEL_PIN_C_OE, COMPARE_OUT_PIN_D_OE}, 3'h1);
    wt(208);
    check("pins", {COMPARE_OUT_PIN_B, COMPARE_OUT_PIN_D, TIMER_IRQ}, 3'h7);
    rd(OFF_STATUS, {RESP_OKAY, 32'h10}, 34'h10);
    rd(OFF_COUNTER, {RESP_OKAY, 32'h0}, 34'hff00);
    $display("test compare done");
    // Each output mode in turn; a repeated high leaves the pin high
    for (int i = 0; i < 5; i++)
    begin
      wr(OFF_IO_CTRL, 32'h0202 | (32'(md[i]) << IO_OUT_B_LSB));
      wr(OFF_COUNTER, 32'hff30);
      wt(40);
      @(negedge CORE_CLK);
      check("pin_b_oe", COMPARE_OUT_PIN_B_OE, i != 0);
      if (i != 0) check("pin_b", COMPARE_OUT_PIN_B, i == 2 || i == 3);
      @(posedge CORE_CLK);
    end
    $display("test modes done");
    wr(OFF_IO_CTRL, 32'h0222);
    wr(OFF_STATUS, 32'h1f);
    wr(OFF_COUNTER, 32'hff30);
    wt(96);
    check("irq", TIMER_IRQ, 1'b0);
    rd(OFF_STATUS, {RESP_OKAY, 32'h0a}, 34'h1b);
    $display("test masking done");
    wr(OFF_COUNTER, 32'h0);
    wr(OFF_STATUS, 32'h1f);
    len <= 8'h1 + 8'($urandom % 4);
    go <= 1'b1;
    @(posedge CORE_CLK);
    go <= 1'b0;
    wt(20);
    rd(OFF_STATUS, {RESP_OKAY, 32'h0}, 34'h1);
    len <= 8'h0;
    go <= 1'b1;
    t1 = cyc;
    @(posedge CORE_CLK);
    go <= 1'b0;
    wt(20);
    check("irq", TIMER_IRQ, 1'b1);
    rd(OFF_STATUS, {RESP_OKAY, 32'h1}, 34'h1);
    rd(OFF_CAPTURE_A, 34'h0, 34'h0);
    a1 = rv;
    go <= 1'b1;
    t2 = cyc;
    @(posedge CORE_CLK);
    go <= 1'b0;
    wt(20);
    rd(OFF_BUFFER_C, {RESP_OKAY, a1}, FULL);
    rd(OFF_CAPTURE_A, {RESP_OKAY, 16'h0, 16'(a1[15:0] + (t2 - t1))}, FULL);
    $display("test capture done");
    // Falling edges only: the pin now rises, so nothing is captured
    wr(OFF_IO_CTRL, 32'h0221);
    wr(OFF_STATUS, 32'h1f);
    go <= 1'b1;
    @(posedge CORE_CLK);
    go <= 1'b0;
    wt(20);
    rd(OFF_STATUS, {RESP_OKAY, 32'h0}, 34'h1);
    $display("test edge select done");
    wr(OFF_START_CTRL, 32'h0);
    wr(OFF_COUNTER, 32'h0100);
    wr(OFF_CAPTURE_A, 32'h0140);
    wr(OFF_START_CTRL, 32'h1);
    wt(100);
    rd(OFF_START_CTRL, {RESP_OKAY, 32'h0}, 34'h1);
    rd(OFF_COUNTER, 34'h0, 34'h0);
    a1 = rv;
    wt(10);
    rd(OFF_COUNTER, {RESP_OKAY, a1}, FULL);
    $display("test stop done");
    finish_test();
  end
endmodule
